// File: logic/nrl_cfg.svh
`ifndef NRL_CFG_SVH
`define NRL_CFG_SVH

// Clock rate and pulse timing.
`define NRL_CLK_HZ 100000000
`define NRL_PULSE_MS 30
`define NRL_PULSE_CYC ((`NRL_CLK_HZ / 1000) * `NRL_PULSE_MS)
// Quiet period that clears the watchdog reset count.
`define NRL_QUIET_MIN 30
`define NRL_QUIET_CYC (64'd60 * `NRL_QUIET_MIN * `NRL_CLK_HZ)
// Most watchdog resets allowed before the loader is held.
`define NRL_WDT_MAX 2'h3
// Hysteresis limits.
`define NRL_HYST_MIN 2'h1
`define NRL_HYST_MAX 2'h2

`endif

// File: logic/nrl_limiter.sv
`include "nrl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module nrl_limiter #(
  parameter logic [37:0] QUIET_CYC = 38'(`NRL_QUIET_CYC),
  parameter logic [21:0] PULSE_CYC = 22'(`NRL_PULSE_CYC)
) (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Interrupt causes.
  input wire logic chassis_cmd_i,
  input wire logic pretimeout_i,
  input wire logic pretimeout_nmi_en_i,
  input wire logic button_n_i,
  // Host state.
  input wire logic host_reset_i,
  input wire logic host_power_down_i,
  // Controller watchdog resets.
  input wire logic wdt_reset_i,
  // Hysteresis setting.
  input wire logic hyst_wr_i,
  input wire logic [1:0] hyst_val_i,
  input wire logic hyst_neg_i,
  // Outputs.
  output logic nmi_o,
  output logic log_nmi_o,
  output logic log_wdt_o,
  output logic halt_loader_o,
  output logic degraded_o,
  output logic [1:0] wdt_count_o,
  output logic [1:0] hyst_o,
  output logic hyst_neg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs.
  logic [1:0] btn_sync;
  logic [1:0] hrst_sync;
  logic [1:0] hpd_sync;
  logic btn_prev;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      btn_sync <= 2'h3;
      hrst_sync <= 2'h0;
      hpd_sync <= 2'h0;
      btn_prev <= 1'b1;
    end else if (ce_i) begin
      btn_sync <= {btn_sync[0], button_n_i};
      hrst_sync <= {hrst_sync[0], host_reset_i};
      hpd_sync <= {hpd_sync[0], host_power_down_i};
      btn_prev <= btn_sync[1];
    end
  end

  logic btn_press;
  logic host_clear;
  assign btn_press = btn_prev & ~btn_sync[1];
  assign host_clear = hrst_sync[1] | hpd_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // State.
  nrl_pkg::nrl_regs_t r;
  nrl_pkg::nrl_regs_t next_r;

  logic pto_cause;
  logic any_cause;
  assign pto_cause = pretimeout_i & pretimeout_nmi_en_i;
  assign any_cause = chassis_cmd_i | pto_cause | btn_press;

  always_comb begin
    next_r = r;
    next_r.log_nmi = 1'b0;
    next_r.log_wdt = 1'b0;
    unique case (r.st)
      nrl_pkg::NRL_IDLE: begin
        if (any_cause) begin
          next_r.st = nrl_pkg::NRL_PULSE;
          next_r.pulse_cnt = 22'h0;
          // Only the button and pre-timeout causes log.
          next_r.log_nmi = pto_cause | btn_press;
        end
      end
      nrl_pkg::NRL_PULSE: begin
        if (r.pulse_cnt >= PULSE_CYC - 22'h1) begin
          next_r.st = nrl_pkg::NRL_LOCKED;
        end else begin
          next_r.pulse_cnt = r.pulse_cnt + 22'h1;
        end
      end
      nrl_pkg::NRL_LOCKED: begin
        if (host_clear) begin
          next_r.st = nrl_pkg::NRL_IDLE;
        end
      end
      default: begin
        // The fourth state code is unused; fall back to idle.
        next_r.st = nrl_pkg::NRL_IDLE;
      end
    endcase
    // Watchdog reset counting and quiet-time clearing.
    if (wdt_reset_i && !r.halt) begin
      next_r.quiet_cnt = 38'h0;
      next_r.log_wdt = 1'b1;
      next_r.degraded = 1'b1;
      if (r.wdt_cnt == `NRL_WDT_MAX) begin
        next_r.halt = 1'b1;
      end else begin
        next_r.wdt_cnt = r.wdt_cnt + 2'h1;
      end
    end else if (!r.halt && r.wdt_cnt != 2'h0) begin
      if (r.quiet_cnt >= QUIET_CYC) begin
        next_r.wdt_cnt = 2'h0;
        next_r.quiet_cnt = 38'h0;
      end else begin
        next_r.quiet_cnt = r.quiet_cnt + 38'h1;
      end
    end
    if (host_clear && !(wdt_reset_i && !r.halt)) begin
      next_r.degraded = 1'b0;
    end
    // Hysteresis accepts only one or two.
    if (hyst_wr_i && hyst_val_i >= `NRL_HYST_MIN && hyst_val_i <= `NRL_HYST_MAX) begin
      next_r.hyst = hyst_val_i;
      next_r.hyst_neg = hyst_neg_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r <= '{st: nrl_pkg::NRL_IDLE, pulse_cnt: 22'h0, wdt_cnt: 2'h0, halt: 1'b0,
             quiet_cnt: 38'h0, degraded: 1'b0, log_nmi: 1'b0, log_wdt: 1'b0,
             hyst: `NRL_HYST_MIN, hyst_neg: 1'b0};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign nmi_o = (r.st == nrl_pkg::NRL_PULSE);
  assign log_nmi_o = r.log_nmi;
  assign log_wdt_o = r.log_wdt;
  assign halt_loader_o = r.halt;
  assign degraded_o = r.degraded;
  assign wdt_count_o = r.wdt_cnt;
  assign hyst_o = r.hyst;
  assign hyst_neg_o = r.hyst_neg;

endmodule

`default_nettype wire

// File: logic/nrl_pkg.sv
`default_nettype none
package nrl_pkg;
  typedef enum logic [1:0] {
    NRL_IDLE,
    NRL_PULSE,
    NRL_LOCKED
  } nrl_state_t;

  typedef struct packed {
    nrl_state_t st;
    logic [21:0] pulse_cnt;
    logic [1:0] wdt_cnt;
    logic halt;
    logic [37:0] quiet_cnt;
    logic degraded;
    logic log_nmi;
    logic log_wdt;
    logic [1:0] hyst;
    logic hyst_neg;
  } nrl_regs_t;
endpackage
`default_nettype wire

// File: verif/nrl_host.sv
`timescale 1ns/100ps
`default_nettype none
module nrl_host (
  input wire logic clk_sys_i,
  input wire logic go_i,
  output logic host_reset_o
);
  logic [2:0] hold = 3'h0;
  always @(posedge clk_sys_i) hold <= go_i ? 3'h4 : hold - 3'(hold != 3'h0);
  assign host_reset_o = hold != 3'h0;
endmodule
`default_nettype wire

// File: verif/nrl_limiter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module nrl_limiter_tb;
  logic clk_sys_i = 0, rst_n_i = 0, cc = 0, pt = 0, pe = 0, bn = 1, w = 0, go = 0, wr = 0;
  logic ng = 0, pd = 0, hr, nmi, ln, lw, hl, dg, hn, sn, sl;
  logic [1:0] hv = 2'h0, cnt, hy;
  logic [5:0] rows [4] = '{6'h22, 6'h1b, 6'h10, 6'h07};
  int bad_count = 0, checks_done = 0, cyc = 0;
  nrl_host host (.clk_sys_i, .go_i(go), .host_reset_o(hr));
  nrl_limiter #(.QUIET_CYC(38'h64), .PULSE_CYC(22'h14)) dut (.clk_sys_i, .rst_n_i, .ce_i(1'b1),
    .chassis_cmd_i(cc), .pretimeout_i(pt), .pretimeout_nmi_en_i(pe), .button_n_i(bn),
    .host_reset_i(hr), .host_power_down_i(pd), .wdt_reset_i(w), .hyst_wr_i(wr),
    .hyst_val_i(hv), .hyst_neg_i(ng), .nmi_o(nmi), .log_nmi_o(ln), .log_wdt_o(lw),
    .halt_loader_o(hl), .degraded_o(dg), .wdt_count_o(cnt), .hyst_o(hy), .hyst_neg_o(hn));
  task automatic chk(string n, logic [3:0] s, logic [3:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tk(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic rearm;
    go = 1;
    tk(1);
    go = 0;
    tk(8);
  endtask
  initial begin
    tk(8);
    rst_n_i = 1;
    chk("rst", {hl, dg, nmi, ln}, 4'h0);
    chk("hyst", {hn, hy}, 4'h1);
    tk(3);
    foreach (rows[i]) begin
      {cc, pt, pe} = rows[i][5:3];
      bn = !rows[i][2];
      tk(1);
      {sn, sl} = {nmi, ln};
      {cc, pt, pe, bn} = 4'h1;
      repeat (6) begin
        tk(1);
        sn |= nmi;
        sl |= ln;
      end
      chk("nmi", sn, rows[i][1]);
      chk("log", sl, rows[i][0]);
      cc = 1;
      tk(25);
      cc = 0;
      chk("lock", nmi, 4'h0);
      rearm;
    end
    w = 1;
    tk(1);
    w = 0;
    chk("wdt", {lw, dg, cnt}, 4'hd);
    tk(100);
    chk("busy", cnt, 4'h1);
    tk(1);
    chk("quiet", {dg, cnt}, 4'h4);
    rearm;
    chk("deg", dg, 4'h0);
    w = 1;
    tk(4);
    w = 0;
    chk("halt", {hl, cnt}, 4'h7);
    {wr, hv, ng} = 4'hd;
    tk(1);
    chk("hys2", {hn, hy}, 4'h6);
    hv = 2'h3;
    tk(1);
    wr = 0;
    chk("hys3", {hn, hy}, 4'h6);
    cc = 1;
    tk(1);
    cc = 0;
    chk("cmd", nmi, 4'h1);
    tk(25);
    pd = 1;
    tk(4);
    pd = 0;
    chk("pdclr", dg, 4'h0);
    tk(4);
    cc = 1;
    tk(1);
    cc = 0;
    chk("rearm", nmi, 4'h1);
    rst_n_i = 0;
    tk(4);
    rst_n_i = 1;
    chk("rst2", {hl, dg, cnt}, 4'h0);
    chk("rst2n", nmi, 4'h0);
    chk("rst2h", {hn, hy}, 4'h1);
    end_of_test;
  end
  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test;
    end
  end
endmodule
`default_nettype wire

// File: verif/nrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nrl_sva #(
  parameter logic [21:0] PULSE_CYC = 22'h14
) (
  input wire logic clk_sys_i, rst_n_i, chassis_cmd_i, pretimeout_i, pretimeout_nmi_en_i,
  input wire logic button_n_i, host_reset_i, host_power_down_i, wdt_reset_i, hyst_wr_i,
  input wire logic nmi_o, log_nmi_o, log_wdt_o, halt_loader_o, degraded_o,
  input wire logic [1:0] hyst_val_i, wdt_count_o, hyst_o
);
  // Counts the cycles for which the interrupt has stood so far.
  logic [21:0] hi_cnt;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !nmi_o) begin
      hi_cnt <= 22'h0;
    end else begin
      hi_cnt <= hi_cnt + 22'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  nmi_width_a: assert property ($fell(nmi_o) |-> $past(hi_cnt) == PULSE_CYC - 22'h1)
    else $error("bad width");
  nmi_lock_a: assert property ($fell(nmi_o) ##0 (!host_reset_i && !host_power_down_i)[*3]
    |-> !nmi_o) else $error("no lock");
  cmd_quiet_a: assert property (chassis_cmd_i && !pretimeout_i && button_n_i |=> !log_nmi_o)
    else $error("cmd logged");
  pre_log_a: assert property ($rose(nmi_o) && $past(pretimeout_i && pretimeout_nmi_en_i)
    |-> log_nmi_o) else $error("no log");
  wdt_log_a: assert property (wdt_reset_i && !halt_loader_o && wdt_count_o != 2'h3 |=>
    log_wdt_o && degraded_o && wdt_count_o == $past(wdt_count_o) + 1) else $error("bad wdt");
  wdt_halt_a: assert property (wdt_reset_i && wdt_count_o == 2'h3 |=> halt_loader_o)
    else $error("no halt");
  halt_keep_a: assert property (halt_loader_o |=> halt_loader_o && $stable(wdt_count_o))
    else $error("halt lost");
  hyst_set_a: assert property (hyst_wr_i && hyst_val_i inside {2'h1, 2'h2} |=>
    hyst_o == $past(hyst_val_i)) else $error("bad hyst");
  cover property ($rose(nmi_o));
  cover property ($rose(halt_loader_o));
  cover property ($fell(degraded_o));
endmodule
bind nrl_limiter nrl_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (.*);
`default_nettype wire
